// >>> include/csp_params.svh
// Constants for the clock source and PLL tuning block.
`ifndef CSP_PARAMS_SVH
`define CSP_PARAMS_SVH
`define CSP_ADDR_TUNE        12'hF9B
`define CSP_ADDR_CTRL        12'hFD3
`define CSP_ADDR_STAT        12'hFD4
`define CSP_TUNE_RESET       8'h00
`define CSP_INTERNAL_FREQ_SELECT_RESET       3'h6
`define CSP_SCS_RESET        2'h0
`define CSP_BIT_LOW_FREQ_SOURCE_SEL       7
`define CSP_BIT_PLL_ENABLE_BIT        6
`define CSP_INTERNAL_FREQ_SELECT_MSB         6
`define CSP_INTERNAL_FREQ_SELECT_LSB         4
`define CSP_SCS_MSB          1
`define CSP_INTERNAL_FREQ_SELECT_8M          3'h7
`define CSP_INTERNAL_FREQ_SELECT_4M          3'h6
`define CSP_INTERNAL_FREQ_SELECT_31K         3'h0
`define CSP_SCS_PRIMARY      2'h0
`define CSP_SCS_TIMER        2'h1
`define CSP_SCS_INTERNAL     2'h3
`define CSP_FOSC_INTERNAL_PLL_MODES_A    3'h3
`define CSP_FOSC_INTERNAL_PLL_MODES_B    3'h2
`define CSP_FOSC_EC          3'h4
`define CSP_FOSC_EXT_CLOCK_PLL_MODE       3'h5
`define CSP_LOCK_TIME_US     2000
`define CSP_CLOCK_MHZ        200
`define CSP_OLD_CYCLES       2
`define CSP_NEW_CYCLES       3
`define CSP_SETTLE_TIME_NS   1000
`define CSP_CLOCK_NS         5
`endif

// >>> include/csp_pkg.sv
// Types shared by the clock source and PLL tuning block.
package csp_pkg;
	typedef struct packed {
		logic       low_freq_source_sel;
		logic       pll_enable_bit;
		logic [5:0] freq_trim_field;
	} csp_tune_type;

	typedef struct packed {
		logic [2:0] internal_freq_select;
		logic [1:0] sys_clock_select;
	} csp_ctrl_type;

	typedef enum logic [1:0] {
		CSP_SW_IDLE = 2'b00,
		CSP_SW_OLD  = 2'b01,
		CSP_SW_NEW  = 2'b10
	} csp_sw_state_type;
endpackage

// >>> rtl/csp_clock_ctrl.sv
// Clock source selection, internal postscaler, PLL control and tuning register.
//
// Behaviour
// - External clock modes need no start-up delay
// - Plain external mode: output is input/4
// - External PLL mode: output is PLL/4
// - Fast oscillator 8 MHz, postscaler 31k-8M
// - 4x PLL on fast oscillator, 32 MHz
// - Slow RC enabled by selection or features
// - Frequency select field picks internal source
// - Trim write settles about 1 us, silently
// - Bit 7 picks fast/256 or slow RC
// - Bit 6 enables or disables PLL
// - PLL needs primary mode 011/010 with select 00, or mode 101
// - PLL in mode 011/010 needs frequency select 111 or 110
// - Keep clock until lock, then switch
// - Signed 6-bit trim around calibrated centre
// - Trim leaves slow RC unchanged
// - Three source classes: primary, secondary, internal
// - Secondary oscillator runs in power-managed modes
// - Slow RC clocks watchdog and fail-safe monitor
// - Select 111 is 8 MHz, 000 is 31 kHz
// - System select 11/01/00, cleared on reset
// - Postscaler defaults to 4 MHz on reset
// - Glitch-free switch: two old, three new cycles
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "csp_params.svh"
module csp_clock_ctrl #(
	parameter int LOCK_CYCLES   = `CSP_LOCK_TIME_US * `CSP_CLOCK_MHZ,
	parameter int FAST_DIV      = 25,
	parameter int SLOW_DIV      = 6452,
	parameter int SETTLE_CYCLES = `CSP_SETTLE_TIME_NS / `CSP_CLOCK_NS
) (
	// Clock and reset
	input  wire logic        i_clock,
	input  wire logic        i_rst_n,
	// Register port
	input  wire logic [11:0] i_addr,
	input  wire logic [7:0]  i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic [7:0]       o_rdata,
	// Configuration and feature enables
	input  wire logic [2:0]  i_primary_mode_config,
	input  wire logic        i_powerup_timer_en,
	input  wire logic        i_fail_safe_monitor_en,
	input  wire logic        i_watchdog_en,
	input  wire logic        i_two_speed_en,
	input  wire logic        i_power_managed,
	// Pins
	input  wire logic        i_clock_in_pin,
	input  wire logic        i_timer_osc_pin,
	output logic             o_clock_out_pin,
	output logic             o_clock_out_oe,
	// Clock enables and status
	output logic             o_device_tick,
	output logic             o_slow_rc_tick,
	output logic             o_slow_rc_en,
	output logic             o_secondary_en,
	output logic             o_pll_ready,
	output logic             o_pll_active,
	output logic             o_switching,
	output logic [5:0]       o_trim_applied
);
	// ==========================================================
	// Registers
	csp_pkg::csp_tune_type     tune_ff;
	csp_pkg::csp_ctrl_type     ctrl_ff;
	logic [7:0]                rdata_ff;
	logic [5:0]                trim_ff;
	logic [15:0]               settle_ff;

	wire wr_tune = i_wr && (i_addr == `CSP_ADDR_TUNE);
	wire wr_ctrl = i_wr && (i_addr == `CSP_ADDR_CTRL);

	// ==========================================================
	// Pin synchronisers
	logic [1:0] ext_sync_ff;
	logic [1:0] t1_sync_ff;
	logic       ext_prev_ff;
	logic       t1_prev_ff;
	wire        ext_edge = ext_sync_ff[1] && !ext_prev_ff;
	wire        t1_edge  = t1_sync_ff[1] && !t1_prev_ff;

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ext_sync_ff <= 2'h0;
			t1_sync_ff  <= 2'h0;
			ext_prev_ff <= 1'b0;
			t1_prev_ff  <= 1'b0;
		end else begin
			ext_sync_ff <= {ext_sync_ff[0], i_clock_in_pin};
			t1_sync_ff  <= {t1_sync_ff[0], i_timer_osc_pin};
			ext_prev_ff <= ext_sync_ff[1];
			t1_prev_ff  <= t1_sync_ff[1];
		end
	end

	// ==========================================================
	// Oscillator model
	wire        pll_mode_int = (i_primary_mode_config == `CSP_FOSC_INTERNAL_PLL_MODES_A) ||
	                           (i_primary_mode_config == `CSP_FOSC_INTERNAL_PLL_MODES_B);
	wire        mode_ec      = (i_primary_mode_config == `CSP_FOSC_EC);
	wire        mode_ext_clock_pll_mode   = (i_primary_mode_config == `CSP_FOSC_EXT_CLOCK_PLL_MODE);
	wire        internal_freq_select_pll_ok  = (ctrl_ff.internal_freq_select == `CSP_INTERNAL_FREQ_SELECT_8M) ||
	                           (ctrl_ff.internal_freq_select == `CSP_INTERNAL_FREQ_SELECT_4M);
	wire        pll_run      = tune_ff.pll_enable_bit && (
	                           (pll_mode_int && internal_freq_select_pll_ok &&
	                            ctrl_ff.sys_clock_select == `CSP_SCS_PRIMARY) || mode_ext_clock_pll_mode);
	wire        pll_ready;
	wire        pll_use      = pll_run && pll_ready;
	wire        fast_tick;
	wire        pll_tick;
	wire        slow_tick;
	logic [9:0] fast_div;
	logic [2:0] sel_old_ff;

	// Trim is signed: positive shortens the fast period, negative lengthens it.
	function automatic logic [9:0] trim_div(input logic [5:0] trim, input int base);
		trim_div = 10'(base - $signed(trim) / 4);
	endfunction

	assign fast_div = trim_div(trim_ff, FAST_DIV) - 10'h1;

	csp_divider #(.WIDTH(10)) u_fast (
		.i_clock      (i_clock),
		.i_rst_n      (i_rst_n),
		.i_enable     (1'b1),
		.i_div_minus1 (fast_div),
		.o_tick       (fast_tick)
	);
	// The 4x multiplier is modelled as a quarter-period tick of the fast oscillator.
	csp_divider #(.WIDTH(10)) u_pll (
		.i_clock      (i_clock),
		.i_rst_n      (i_rst_n),
		.i_enable     (pll_use),
		.i_div_minus1 ((fast_div >> 2)),
		.o_tick       (pll_tick)
	);
	// Slow RC never sees the trim value.
	csp_divider #(.WIDTH(13)) u_slow (
		.i_clock      (i_clock),
		.i_rst_n      (i_rst_n),
		.i_enable     (o_slow_rc_en),
		.i_div_minus1 (13'(SLOW_DIV - 1)),
		.o_tick       (slow_tick)
	);
	csp_pll_lock #(.LOCK_CYCLES(LOCK_CYCLES)) u_lock (
		.i_clock (i_clock),
		.i_rst_n (i_rst_n),
		.i_run   (pll_run),
		.o_ready (pll_ready)
	);

	// ==========================================================
	// Postscaler
	logic [7:0] post_cnt_ff;
	logic [7:0] post_prev_ff;
	logic       post_tick;
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			post_cnt_ff  <= 8'h0;
			post_prev_ff <= 8'h0;
		end else if (fast_tick) begin
			post_prev_ff <= post_cnt_ff;
			post_cnt_ff  <= post_cnt_ff + 8'h1;
		end
	end
	// Tap n pulses on the rising edge of bit n-1 of the postscaler counter.
	function automatic logic tap(input logic [7:0] c, input logic [7:0] p, input int n);
		tap = c[n-1] && !p[n-1];
	endfunction
	always_comb begin
		post_tick = 1'b0;
		case (ctrl_ff.internal_freq_select)
		3'h7: post_tick = fast_tick;
		3'h6: post_tick = fast_tick && tap(post_cnt_ff, post_prev_ff, 1);
		3'h5: post_tick = fast_tick && tap(post_cnt_ff, post_prev_ff, 2);
		3'h4: post_tick = fast_tick && tap(post_cnt_ff, post_prev_ff, 3);
		3'h3: post_tick = fast_tick && tap(post_cnt_ff, post_prev_ff, 4);
		3'h2: post_tick = fast_tick && tap(post_cnt_ff, post_prev_ff, 5);
		3'h1: post_tick = fast_tick && tap(post_cnt_ff, post_prev_ff, 6);
		default: post_tick = tune_ff.low_freq_source_sel ?
		                     (fast_tick && post_cnt_ff == 8'hFF) : slow_tick;
		endcase
	end

	// ==========================================================
	// Source selection
	logic primary_tick;
	logic src_tick;
	logic [2:0] sel_now;
	always_comb begin
		if (mode_ec || mode_ext_clock_pll_mode) begin
			primary_tick = (mode_ext_clock_pll_mode && pll_use) ? pll_tick : ext_edge;
		end else if (pll_mode_int) begin
			primary_tick = pll_use ? pll_tick : post_tick;
		end else begin
			primary_tick = post_tick;
		end
		case (ctrl_ff.sys_clock_select)
		`CSP_SCS_TIMER:    sel_now = 3'h1;
		`CSP_SCS_INTERNAL: sel_now = 3'h2;
		default:           sel_now = {2'h0, pll_use} + 3'h4;
		endcase
	end
	function automatic logic pick(input logic [2:0] s, input logic p, input logic t, input logic i);
		pick = (s == 3'h1) ? t : (s == 3'h2) ? i : p;
	endfunction
	assign src_tick = pick(sel_now, primary_tick, t1_edge, post_tick);

	// ==========================================================
	// Glitch-free switch
	csp_pkg::csp_sw_state_type state_ff;
	logic [2:0] sw_cnt_ff;
	wire        old_tick = pick(sel_old_ff, primary_tick, t1_edge, post_tick);
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_ff   <= csp_pkg::CSP_SW_IDLE;
			sw_cnt_ff  <= 3'h0;
			sel_old_ff <= 3'h4;
		end else begin
			case (state_ff)
			csp_pkg::CSP_SW_IDLE: if (sel_now != sel_old_ff) begin
				state_ff  <= csp_pkg::CSP_SW_OLD;
				sw_cnt_ff <= 3'h0;
			end
			csp_pkg::CSP_SW_OLD: if (old_tick) begin
				sw_cnt_ff <= (sw_cnt_ff == 3'(`CSP_OLD_CYCLES - 1)) ? 3'h0 : sw_cnt_ff + 3'h1;
				if (sw_cnt_ff == 3'(`CSP_OLD_CYCLES - 1)) state_ff <= csp_pkg::CSP_SW_NEW;
			end
			csp_pkg::CSP_SW_NEW: if (src_tick) begin
				sw_cnt_ff <= sw_cnt_ff + 3'h1;
				if (sw_cnt_ff == 3'(`CSP_NEW_CYCLES - 1)) begin
					state_ff   <= csp_pkg::CSP_SW_IDLE;
					sel_old_ff <= sel_now;
				end
			end
			default: state_ff <= csp_pkg::CSP_SW_IDLE;
			endcase
		end
	end
	assign o_switching   = (state_ff != csp_pkg::CSP_SW_IDLE);
	assign o_device_tick = !o_switching && src_tick;

	// ==========================================================
	// Clock output divide-by-four
	logic       out_cnt_ff;
	logic       out_ff;
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			out_cnt_ff <= 1'b0;
			out_ff     <= 1'b0;
		end else if (primary_tick) begin
			out_cnt_ff <= !out_cnt_ff;
			if (out_cnt_ff) out_ff <= !out_ff;
		end
	end
	assign o_clock_out_pin = out_ff;
	assign o_clock_out_oe  = mode_ec || mode_ext_clock_pll_mode;

	// ==========================================================
	// Other outputs
	assign o_slow_rc_en = i_powerup_timer_en || i_fail_safe_monitor_en || i_watchdog_en ||
	                      i_two_speed_en || (ctrl_ff.internal_freq_select == `CSP_INTERNAL_FREQ_SELECT_31K &&
	                      !tune_ff.low_freq_source_sel);
	assign o_slow_rc_tick = slow_tick;
	// Secondary stays enabled while selected, also in power-managed modes.
	assign o_secondary_en = i_power_managed || (ctrl_ff.sys_clock_select == `CSP_SCS_TIMER);
	assign o_pll_ready    = pll_ready;
	assign o_pll_active   = pll_use;
	assign o_trim_applied = trim_ff;
	assign o_rdata        = rdata_ff;

	// ==========================================================
	// Register file
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tune_ff   <= `CSP_TUNE_RESET;
			ctrl_ff   <= {`CSP_INTERNAL_FREQ_SELECT_RESET, `CSP_SCS_RESET};
			rdata_ff  <= 8'h00;
			trim_ff   <= 6'h00;
			settle_ff <= 16'h0;
		end else begin
			if (wr_tune) tune_ff <= i_wdata;
			if (wr_ctrl) ctrl_ff <= {i_wdata[`CSP_INTERNAL_FREQ_SELECT_MSB:`CSP_INTERNAL_FREQ_SELECT_LSB], i_wdata[`CSP_SCS_MSB:0]};
			// Trim takes the new value in one step after a short delay; nothing reports it.
			if (wr_tune) settle_ff <= 16'(SETTLE_CYCLES);
			else if (settle_ff != 16'h0) settle_ff <= settle_ff - 16'h1;
			if (settle_ff == 16'h1) trim_ff <= tune_ff.freq_trim_field;
			rdata_ff <= 8'h00;
			if (i_rd) begin
				case (i_addr)
				`CSP_ADDR_TUNE: rdata_ff <= tune_ff;
				`CSP_ADDR_CTRL: rdata_ff <= {1'b0, ctrl_ff.internal_freq_select, 1'b0, 1'b1,
				                             ctrl_ff.sys_clock_select};
				`CSP_ADDR_STAT: rdata_ff <= {4'h0, o_switching, pll_ready, pll_use, pll_run};
				default:        rdata_ff <= 8'h00;
				endcase
			end
		end
	end

	// ==========================================================
	// Checks
	property p_rst_sel;
		@(posedge i_clock) disable iff (!i_rst_n)
		$rose(i_rst_n) |-> ctrl_ff.sys_clock_select == `CSP_SCS_PRIMARY;
	endproperty
	a_rst_sel: assert property (p_rst_sel) else $error("select not cleared");
	property p_pll_gate;
		@(posedge i_clock) disable iff (!i_rst_n)
		pll_use |-> tune_ff.pll_enable_bit && (mode_ext_clock_pll_mode || internal_freq_select_pll_ok);
	endproperty
	a_pll_gate: assert property (p_pll_gate) else $error("pll used without enable");
	property p_pll_mode;
		@(posedge i_clock) disable iff (!i_rst_n)
		pll_use && !mode_ext_clock_pll_mode |-> pll_mode_int && ctrl_ff.sys_clock_select == `CSP_SCS_PRIMARY;
	endproperty
	a_pll_mode: assert property (p_pll_mode) else $error("pll outside its modes");
	property p_lock;
		@(posedge i_clock) disable iff (!i_rst_n)
		$rose(pll_run) |-> !pll_use [*8];
	endproperty
	a_lock: assert property (p_lock) else $error("pll used before lock");
	property p_quiet;
		@(posedge i_clock) disable iff (!i_rst_n)
		$rose(o_switching) |-> o_switching [*5];
	endproperty
	a_quiet: assert property (p_quiet) else $error("switch pause too short");
	property p_slow;
		@(posedge i_clock) disable iff (!i_rst_n)
		i_watchdog_en || i_fail_safe_monitor_en |-> o_slow_rc_en;
	endproperty
	a_slow: assert property (p_slow) else $error("slow rc off");
	property p_trim;
		@(posedge i_clock) disable iff (!i_rst_n)
		wr_tune && settle_ff != 16'h1 |=> trim_ff == $past(trim_ff);
	endproperty
	a_trim: assert property (p_trim) else $error("trim applied instantly");
	property p_oe;
		@(posedge i_clock) disable iff (!i_rst_n)
		mode_ec |-> o_clock_out_oe;
	endproperty
	a_oe: assert property (p_oe) else $error("clock out not driven");
	property p_ec_tick;
		@(posedge i_clock) disable iff (!i_rst_n)
		mode_ec && ctrl_ff.sys_clock_select == `CSP_SCS_PRIMARY && !o_switching && ext_edge
		|-> o_device_tick;
	endproperty
	a_ec_tick: assert property (p_ec_tick) else $error("external edge not passed on");
	c_switch: cover property (@(posedge i_clock) disable iff (!i_rst_n) $fell(o_switching));
	c_pll:    cover property (@(posedge i_clock) disable iff (!i_rst_n) $rose(pll_use));
	c_lowf:   cover property (@(posedge i_clock) disable iff (!i_rst_n)
	                          tune_ff.low_freq_source_sel && post_tick);
endmodule
`default_nettype wire

// >>> rtl/csp_divider.sv
// Programmable enable-pulse divider used for the clock taps.
`timescale 1ns/100ps
`default_nettype none
module csp_divider #(
	parameter int WIDTH = 10
) (
	// Clock and reset
	input  wire logic             i_clock,
	input  wire logic             i_rst_n,
	// Tap control
	input  wire logic             i_enable,
	input  wire logic [WIDTH-1:0] i_div_minus1,
	// Output
	output logic                  o_tick
);
	logic [WIDTH-1:0] count_ff;
	logic             tick_ff;
	wire              wrap = (count_ff >= i_div_minus1);

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			count_ff <= '0;
			tick_ff  <= 1'b0;
		end else begin
			count_ff <= (!i_enable || wrap) ? '0 : count_ff + 1'b1;
			tick_ff  <= i_enable && wrap;
		end
	end
	assign o_tick = tick_ff;
endmodule
`default_nettype wire

// >>> rtl/csp_pll_lock.sv
// Lock timer of the 4x frequency multiplier.
`timescale 1ns/100ps
`default_nettype none
module csp_pll_lock #(
	parameter int LOCK_CYCLES = 400000
) (
	// Clock and reset
	input  wire logic i_clock,
	input  wire logic i_rst_n,
	// Control
	input  wire logic i_run,
	// Status
	output logic      o_ready
);
	logic [31:0] count_ff;
	logic        ready_ff;

	// Counting restarts whenever the multiplier loses its qualifying conditions.
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			count_ff <= 32'h0;
			ready_ff <= 1'b0;
		end else if (!i_run) begin
			count_ff <= 32'h0;
			ready_ff <= 1'b0;
		end else if (count_ff >= 32'(LOCK_CYCLES - 1)) begin
			ready_ff <= 1'b1;
		end else begin
			count_ff <= count_ff + 32'h1;
		end
	end
	assign o_ready = ready_ff;
endmodule
`default_nettype wire

// >>> tb/csp_clock_ctrl_tb.sv
// Self-checking testbench of the clock source and PLL tuning block.
`timescale 1ns/100ps
`default_nettype none
`include "csp_params.svh"
module csp_clock_ctrl_tb;
	localparam int LOCK   = 200;
	localparam int SETTLE = 20;
	localparam int LIMIT  = 40000;
	logic        i_clock;
	logic        i_rst_n;
	logic [11:0] i_addr;
	logic [7:0]  i_wdata;
	logic        i_wr;
	logic        i_rd;
	logic [7:0]  o_rdata;
	logic [2:0]  i_primary_mode_config;
	logic [3:0]  feat;
	logic        i_power_managed;
	logic        i_clock_in_pin;
	logic        i_timer_osc_pin;
	logic        o_clock_out_pin;
	logic        o_clock_out_oe;
	logic        o_device_tick;
	logic        o_slow_rc_tick;
	logic        o_slow_rc_en;
	logic        o_secondary_en;
	logic        o_pll_ready;
	logic        o_pll_active;
	logic        o_switching;
	logic [5:0]  o_trim_applied;
	logic [3:0]  pin_cnt_ff;
	logic        last_out;
	int          num_errors;
	int          total_checks;
	int          cycles;
	int          dev_cnt;
	int          tog_cnt;
	int          slow_cnt;
	int          sw_bad;
	int          sw_seen;
	int          dev_lo;

	csp_clock_ctrl #(.LOCK_CYCLES(LOCK), .FAST_DIV(25), .SLOW_DIV(40), .SETTLE_CYCLES(SETTLE)) uut (
		.i_clock(i_clock), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
		.i_rd(i_rd), .o_rdata(o_rdata), .i_primary_mode_config(i_primary_mode_config),
		.i_powerup_timer_en(feat[0]), .i_fail_safe_monitor_en(feat[1]), .i_watchdog_en(feat[2]),
		.i_two_speed_en(feat[3]), .i_power_managed(i_power_managed), .i_clock_in_pin(i_clock_in_pin),
		.i_timer_osc_pin(i_timer_osc_pin), .o_clock_out_pin(o_clock_out_pin), .o_clock_out_oe(o_clock_out_oe),
		.o_device_tick(o_device_tick), .o_slow_rc_tick(o_slow_rc_tick), .o_slow_rc_en(o_slow_rc_en),
		.o_secondary_en(o_secondary_en), .o_pll_ready(o_pll_ready), .o_pll_active(o_pll_active),
		.o_switching(o_switching), .o_trim_applied(o_trim_applied));

	// ==========================================================
	// Clock, pin stimulus and hang guard
	always #2.5 i_clock = ~i_clock;

	// The external pin rises every 4 cycles, the timer pin every 16.
	always @(posedge i_clock) begin
		pin_cnt_ff      <= pin_cnt_ff + 4'h1;
		i_clock_in_pin  <= pin_cnt_ff[1];
		i_timer_osc_pin <= pin_cnt_ff[3];
		cycles          <= cycles + 1;
		if (cycles == LIMIT) begin
			num_errors++;
			complete_run();
		end
	end

	// ==========================================================
	// Shared tasks
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %s expected %0h seen %0h", name, exp, got);
		end
	endtask

	task automatic do_reset(input logic [2:0] mode);
		@(posedge i_clock);
		i_rst_n               <= 1'b0;
		i_primary_mode_config <= mode;
		repeat (10) @(posedge i_clock);
		i_rst_n <= 1'b1;
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge i_clock);
		i_wr    <= 1'b1;
		i_addr  <= a;
		i_wdata <= d;
		@(posedge i_clock);
		i_wr <= 1'b0;
	endtask

	task automatic rchk(input string name, input logic [11:0] a, input logic [7:0] exp);
		@(posedge i_clock);
		i_rd   <= 1'b1;
		i_addr <= a;
		@(posedge i_clock);
		i_rd <= 1'b0;
		#1;
		chk(name, {24'h0, exp}, {24'h0, o_rdata});
	endtask

	// Counts ticks and output toggles; device ticks inside a switch pause are faults.
	task automatic run(input int n);
		dev_cnt  = 0;
		tog_cnt  = 0;
		slow_cnt = 0;
		repeat (n) begin
			@(posedge i_clock);
			#1;
			dev_cnt  += int'(o_device_tick === 1'b1);
			slow_cnt += int'(o_slow_rc_tick === 1'b1);
			tog_cnt  += int'(o_clock_out_pin !== last_out);
			last_out = o_clock_out_pin;
			sw_seen  += int'(o_switching === 1'b1);
			sw_bad   += int'(o_switching === 1'b1 && o_device_tick !== 1'b0);
		end
	endtask

	task automatic complete_run();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	task automatic s_reset_regs();
		do_reset(`CSP_FOSC_INTERNAL_PLL_MODES_A);
		rchk("tune_reset", `CSP_ADDR_TUNE, `CSP_TUNE_RESET);
		rchk("ctrl_reset", `CSP_ADDR_CTRL, 8'h64);
		wr(12'h123, 8'hFF);
		rchk("unmapped", 12'h123, 8'h00);
		wr(`CSP_ADDR_TUNE, 8'hBF);
		rchk("tune_rw", `CSP_ADDR_TUNE, 8'hBF);
	endtask

	task automatic s_trim();
		@(posedge i_clock);
		feat <= 4'h4;
		wr(`CSP_ADDR_TUNE, 8'h20);
		run(SETTLE + 4);
		chk("trim_min", 32'h20, {26'h0, o_trim_applied});
		run(400);
		dev_lo = dev_cnt;
		chk("slow_min", 32'h1, 32'(slow_cnt >= 9 && slow_cnt <= 11));
		wr(`CSP_ADDR_TUNE, 8'h1F);
		run(SETTLE + 4);
		chk("trim_max", 32'h1F, {26'h0, o_trim_applied});
		run(400);
		chk("fast_up", 32'h1, 32'(dev_cnt > dev_lo));
		chk("slow_max", 32'h1, 32'(slow_cnt >= 9 && slow_cnt <= 11));
		wr(`CSP_ADDR_TUNE, 8'h00);
		run(SETTLE + 4);
		chk("trim_mid", 32'h0, {26'h0, o_trim_applied});
	endtask

	task automatic s_slow_rc();
		for (int i = 0; i < 4; i++) begin
			@(posedge i_clock);
			feat <= 4'h1 << i;
			run(2);
			chk("slow_en_feat", 32'h1, {31'h0, o_slow_rc_en});
		end
		@(posedge i_clock);
		feat <= 4'h0;
		run(2);
		chk("slow_en_off", 32'h0, {31'h0, o_slow_rc_en});
	endtask

	task automatic s_pll(input logic [2:0] mode);
		do_reset(mode);
		wr(`CSP_ADDR_TUNE, 8'h40);
		run(LOCK - 10);
		chk("pll_early", 32'h0, {30'h0, o_pll_ready, o_pll_active});
		chk("keeps_clock", 32'h1, 32'(dev_cnt > 0));
		run(20);
		chk("pll_locked", 32'h3, {30'h0, o_pll_ready, o_pll_active});
		// The switch onto the multiplier has to finish before status reads idle.
		run(60);
		rchk("status", `CSP_ADDR_STAT, 8'h07);
		wr(`CSP_ADDR_TUNE, 8'h00);
		run(3);
		chk("pll_off", 32'h0, {31'h0, o_pll_active});
		wr(`CSP_ADDR_CTRL, 8'h50);
		wr(`CSP_ADDR_TUNE, 8'h40);
		run(LOCK + 20);
		chk("pll_ircf5", 32'h0, {31'h0, o_pll_active});
		wr(`CSP_ADDR_CTRL, 8'h70);
		run(LOCK + 20);
		chk("pll_ircf7", 32'h1, {31'h0, o_pll_active});
		wr(`CSP_ADDR_CTRL, 8'h71);
		run(3);
		chk("pll_scs1", 32'h0, {31'h0, o_pll_active});
	endtask

	task automatic s_ext();
		do_reset(`CSP_FOSC_EC);
		run(20);
		chk("ec_no_delay", 32'h1, 32'(dev_cnt > 0));
		chk("ec_oe", 32'h1, {31'h0, o_clock_out_oe});
		run(160);
		chk("ec_div4", 32'h1, 32'(tog_cnt >= 19 && tog_cnt <= 21));
		wr(`CSP_ADDR_TUNE, 8'h40);
		run(LOCK + 20);
		chk("ec_no_pll", 32'h0, {31'h0, o_pll_active});
		do_reset(`CSP_FOSC_EXT_CLOCK_PLL_MODE);
		wr(`CSP_ADDR_TUNE, 8'h40);
		run(LOCK + 20);
		chk("ext_clock_pll_mode_pll", 32'h3, {30'h0, o_clock_out_oe, o_pll_active});
		run(60);
		run(200);
		chk("ext_clock_pll_mode_div4", 32'h1, 32'(dev_cnt >= 20 && tog_cnt * 2 >= dev_cnt - 2 && tog_cnt * 2 <= dev_cnt + 2));
	endtask

	task automatic s_switch();
		do_reset(`CSP_FOSC_INTERNAL_PLL_MODES_A);
		sw_bad  = 0;
		sw_seen = 0;
		wr(`CSP_ADDR_CTRL, 8'h03);
		run(2000);
		chk("sw_seen", 32'h1, 32'(sw_seen >= 5));
		chk("sw_quiet", 32'h0, 32'(sw_bad));
		chk("sw_done", 32'h0, {31'h0, o_switching});
		chk("slow_sel", 32'h1, {31'h0, o_slow_rc_en});
		rchk("ctrl_int", `CSP_ADDR_CTRL, 8'h07);
		wr(`CSP_ADDR_CTRL, 8'h73);
		run(500);
		chk("internal_freq_select_8m", 32'h1, 32'(dev_cnt >= 19 && dev_cnt <= 21));
		wr(`CSP_ADDR_CTRL, 8'h43);
		run(1000);
		chk("internal_freq_select_1m", 32'h1, 32'(dev_cnt >= 4 && dev_cnt <= 6));
		wr(`CSP_ADDR_CTRL, 8'h03);
		wr(`CSP_ADDR_TUNE, 8'h80);
		run(6500);
		chk("lowf_div256", 32'h1, 32'(dev_cnt >= 1 && dev_cnt <= 2));
		chk("lowf_rc_off", 32'h0, {31'h0, o_slow_rc_en});
		@(posedge i_clock);
		i_power_managed <= 1'b1;
		wr(`CSP_ADDR_CTRL, 8'h61);
		run(2000);
		chk("secondary", 32'h1, {31'h0, o_secondary_en});
		chk("sw_quiet2", 32'h0, 32'(sw_bad));
		wr(`CSP_ADDR_CTRL, 8'h60);
		run(2);
		chk("secondary_pm", 32'h1, {31'h0, o_secondary_en});
		@(posedge i_clock);
		i_power_managed <= 1'b0;
		run(2);
		chk("secondary_off", 32'h0, {31'h0, o_secondary_en});
		do_reset(`CSP_FOSC_INTERNAL_PLL_MODES_A);
		rchk("ctrl_clear", `CSP_ADDR_CTRL, 8'h64);
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		i_clock               = 1'b0;
		i_rst_n               = 1'b0;
		i_addr                = 12'h000;
		i_wdata               = 8'h00;
		i_wr                  = 1'b0;
		i_rd                  = 1'b0;
		i_primary_mode_config = 3'h3;
		feat                  = 4'h0;
		i_power_managed       = 1'b0;
		i_clock_in_pin        = 1'b0;
		i_timer_osc_pin       = 1'b0;
		pin_cnt_ff            = 4'h0;
		last_out              = 1'b0;
		num_errors            = 0;
		total_checks          = 0;
		cycles                = 0;
		sw_bad                = 0;
		sw_seen               = 0;
		s_reset_regs();
		s_trim();
		s_slow_rc();
		s_pll(`CSP_FOSC_INTERNAL_PLL_MODES_A);
		s_pll(`CSP_FOSC_INTERNAL_PLL_MODES_B);
		s_ext();
		s_switch();
		complete_run();
	end
endmodule
`default_nettype wire
